//--- rtl/hbh_port.sv
// Host bus handshake port: wait line, sync done, decode hit, data path
`timescale 1ns/1ps
module hbh_port #(
  parameter int DATA_W = hbh_pkg::DATA_W
) (
  // Clock (crystal domain), reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Host pins from outside the clock domain
  input wire logic i_local_bus_clock,
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  input wire logic i_ready_return_in_n,
  input wire logic i_datapath_select_n,
  input wire logic i_cycle_n,
  input wire logic i_direction_select,
  input wire logic i_bus_mode_select_n,
  input wire logic i_address_qualifier_n,
  input wire logic [hbh_pkg::ADDR_HI:hbh_pkg::ADDR_LO] i_addr,
  input wire logic [3:0] i_byte_lane_enable_n,
  input wire logic [DATA_W-1:0] i_host_data,
  // Configuration and status from the device core
  input wire logic i_zero_wait,
  input wire logic [7:0] i_base_high,
  input wire logic [3:0] i_rd_fifo_bytes,
  input wire logic i_wr_fifo_full,
  input wire logic i_status_event,
  // Open-drain wait line
  output logic o_async_wait_release_o,
  output logic o_async_wait_release_oe,
  // Sync outputs to host
  output logic o_sync_done_n,
  output logic o_host_irq_out,
  output logic o_local_decode_hit_n,
  output logic o_datapath_active,
  // Data words to the packet path
  output logic o_word_valid,
  input wire logic i_word_ready,
  output hbh_pkg::hbh_word_t o_word
);
  import hbh_pkg::*;

  // Idle pin levels: bus clock parked low, strobes and selects high
  localparam hbh_pins_t PINS_IDLE = '{bus_clk: RST_LOW, default: RST_HIGH};

  // Three-stage samplers for host pins
  hbh_pins_t pins_raw;
  hbh_pins_t smp1;
  hbh_pins_t smp2;
  hbh_pins_t smp3;
  hbh_pins_t pins;  // Stable value, updated when stages two and three agree

  assign pins_raw = '{bus_clk: i_local_bus_clock, rd_n: i_read_strobe_n,
                      wr_n: i_write_strobe_n, rdy_ret_n: i_ready_return_in_n,
                      dsel_n: i_datapath_select_n, cycle_n: i_cycle_n};

  // Sampler chain, reset to idle levels so no false bus clock edge follows reset
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      smp1 <= PINS_IDLE;
      smp2 <= PINS_IDLE;
      smp3 <= PINS_IDLE;
    end else if (i_ce) begin
      smp1 <= pins_raw;
      smp2 <= smp1;
      smp3 <= smp2;
    end
  end

  // Per-bit agreement filter
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pins <= PINS_IDLE;
    end else if (i_ce) begin
      for (int b = 0; b < $bits(hbh_pins_t); b++) begin
        if (smp2[b] == smp3[b]) begin
          pins[b] <= smp2[b];
        end
      end
    end
  end

  // Bus clock edge detection
  logic clk_prev;
  logic clk_rise;
  logic clk_fall;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_prev <= RST_LOW;
    end else if (i_ce) begin
      clk_prev <= pins.bus_clk;
    end
  end
  assign clk_rise = pins.bus_clk && !clk_prev;
  assign clk_fall = !pins.bus_clk && clk_prev;

  // Async cycle status from the strobes
  logic async_rd;
  logic async_wr;
  assign async_rd = !pins.rd_n;
  assign async_wr = !pins.wr_n;

  // Stall conditions for the wait line
  logic next_stall;
  always_comb begin
    next_stall = 1'b0;
    if (async_rd || async_wr) begin
      if (!i_zero_wait) begin
        next_stall = 1'b1;
      end else if (async_rd && (i_rd_fifo_bytes < RD_MIN_BYTES)) begin
        next_stall = 1'b1;
      end else if (async_wr && i_wr_fifo_full) begin
        next_stall = 1'b1;
      end
    end
  end

  // Open-drain wait line, release timed by the crystal clock
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_async_wait_release_oe <= RST_LOW;
    end else if (i_ce) begin
      o_async_wait_release_oe <= next_stall;
    end
  end
  // Only ever pulls low
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_async_wait_release_o <= RST_LOW;
    end else if (i_ce) begin
      o_async_wait_release_o <= RST_LOW;
    end
  end

  // Decode hit straight from pins, no strobe latch, registered for output
  logic next_hit_n;
  assign next_hit_n = !(!i_address_qualifier_n &&
                        (i_addr[ADDR_HI:ADDR_HI-7] == i_base_high));
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_local_decode_hit_n <= RST_HIGH;
    end else if (i_ce) begin
      o_local_decode_hit_n <= next_hit_n;
    end
  end

  // Interrupt output follows status events
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_host_irq_out <= RST_LOW;
    end else if (i_ce) begin
      o_host_irq_out <= i_status_event;
    end
  end

  // Data-path select, independent of qualifier and address
  logic dsel;
  assign dsel = !pins.dsel_n;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_datapath_active <= RST_LOW;
    end else if (i_ce) begin
      o_datapath_active <= dsel;
    end
  end

  // Sync cycle machine, stepped on bus clock edges
  hbh_state_t state;
  hbh_state_t next_state;
  logic vl_mode;
  logic sync_req;
  logic buf_ready;
  logic push;
  assign vl_mode = !i_bus_mode_select_n;
  assign sync_req = dsel && !pins.cycle_n;

  always_comb begin
    next_state = state;
    case (state)
      HBH_IDLE: begin
        if (sync_req && clk_rise) begin
          next_state = HBH_WAIT;
        end
      end
      HBH_WAIT: begin
        if (vl_mode) begin
          // VL: complete on next rising edge when buffer has room, or on that edge without waiting for room on a read
          if (clk_rise && (buf_ready || !i_direction_select)) begin
            next_state = HBH_DONE;
          end
        end else if (clk_fall && !pins.rdy_ret_n && !i_direction_select) begin
          next_state = HBH_WAIT;
        end else if (clk_fall && (buf_ready || !i_direction_select)) begin
          next_state = HBH_DONE;
        end
      end
      HBH_DONE: begin
        if (clk_rise) begin
          next_state = HBH_IDLE;
        end
      end
      default: begin
        next_state = HBH_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= HBH_IDLE;
    end else if (i_ce) begin
      state <= next_state;
    end
  end

  // Completion output, changes only after a bus clock edge
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_sync_done_n <= RST_HIGH;
    end else if (i_ce) begin
      o_sync_done_n <= !(vl_mode && next_state == HBH_DONE);
    end
  end

  // Capture a write word on completion, 32 bits, byte lanes ignored
  hbh_word_t in_word;
  assign in_word = '{dir_write: i_direction_select, data: i_host_data};
  assign push = (state == HBH_WAIT) && (next_state == HBH_DONE) && i_direction_select;

  logic buf_valid;
  hbh_word_t buf_word;
  logic o_word_valid_hold;  // Output word waiting on a stalled receiver
  hbh_buf #(
    .DEPTH(BUF_DEPTH)
  ) u_buf (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_valid(push),
    .o_ready(buf_ready),
    .i_word(in_word),
    .o_valid(buf_valid),
    .i_ready(!o_word_valid_hold),
    .o_word(buf_word)
  );

  // Output register stage; loads whenever it is not holding, so valid never waits on ready
  assign o_word_valid_hold = o_word_valid && !i_word_ready;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_word_valid <= RST_LOW;
      o_word <= '0;
    end else if (i_ce) begin
      if (!o_word_valid_hold) begin
        o_word_valid <= buf_valid;
        o_word <= buf_word;
      end
    end
  end
endmodule : hbh_port

//--- common/hbh_pkg.sv
// Package with constants and carrier types for the host bus handshake port
package hbh_pkg;

  // Data path width and read FIFO threshold
  localparam int DATA_W = 32;
  localparam logic [3:0] RD_MIN_BYTES = 4'h4;
  // Address decode field
  localparam int ADDR_LO = 4;
  localparam int ADDR_HI = 15;
  localparam int DEC_W = ADDR_HI - ADDR_LO + 1;
  // Link clock sampling and buffer
  localparam int SYNC_STAGES = 3;
  localparam int BUF_DEPTH = 2;
  // Reset values
  localparam logic RST_HIGH = 1'b1;
  localparam logic RST_LOW = 1'b0;

  // Word carried through the data buffer
  typedef struct packed {
    logic dir_write;
    logic [DATA_W-1:0] data;
  } hbh_word_t;

  // Sampled host pins
  typedef struct packed {
    logic bus_clk;
    logic rd_n;
    logic wr_n;
    logic rdy_ret_n;
    logic dsel_n;
    logic cycle_n;
  } hbh_pins_t;

  // Sync cycle state machine
  typedef enum logic [1:0] {
    HBH_IDLE = 2'b00,
    HBH_WAIT = 2'b01,
    HBH_DONE = 2'b10
  } hbh_state_t;

endpackage : hbh_pkg

//--- rtl/hbh_buf.sv
// Two-entry valid/ready buffer for data words
`timescale 1ns/1ps
module hbh_buf #(
  parameter int DEPTH = 2
) (
  // Clock, reset, enable
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  // Fill side
  input wire logic i_valid,
  output logic o_ready,
  input wire hbh_pkg::hbh_word_t i_word,
  // Drain side
  output logic o_valid,
  input wire logic i_ready,
  output hbh_pkg::hbh_word_t o_word
);
  import hbh_pkg::*;

  localparam int PW = $clog2(DEPTH);
  // Storage and pointers
  hbh_word_t mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;
  assign o_ready = (count != (PW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign o_word = mem[rd_ptr];

  // Write storage
  always_ff @(posedge i_mclk) begin
    if (i_ce && push) begin
      mem[wr_ptr] <= i_word;
    end
  end

  // Pointers and fill count
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : hbh_buf

//--- test/hbh_port_checker.sv
// Checker for the host bus handshake port
`timescale 1ns/1ps
module hbh_port_checker (
  // Clock, reset and host pins
  input wire logic i_mclk, i_rst_n, i_ce, i_read_strobe_n, i_write_strobe_n,
  input wire logic i_bus_mode_select_n, i_address_qualifier_n, i_datapath_select_n,
  input wire logic [hbh_pkg::ADDR_HI:hbh_pkg::ADDR_LO] i_addr,
  // Core levels
  input wire logic i_zero_wait, i_wr_fifo_full, i_status_event,
  input wire logic [7:0] i_base_high,
  input wire logic [3:0] i_rd_fifo_bytes,
  // Watched outputs
  input wire logic o_async_wait_release_o, o_async_wait_release_oe,
  input wire logic o_sync_done_n, o_host_irq_out, o_local_decode_hit_n, o_datapath_active
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  // Address match as seen at the pins
  logic hit;
  assign hit = !i_address_qualifier_n && i_addr[15:8] == i_base_high;
  // Read held with too few bytes buffered
  sequence s_rd_short;
    (!i_read_strobe_n && i_write_strobe_n && i_zero_wait && i_rd_fifo_bytes < 4'h4)[*8];
  endsequence
  property p_pin; !o_async_wait_release_o; endproperty
  property p_nowait;
    (!i_zero_wait && !(i_read_strobe_n && i_write_strobe_n))[*8] |-> o_async_wait_release_oe;
  endproperty
  property p_rd; s_rd_short |-> o_async_wait_release_oe; endproperty
  property p_rd_ok;
    (!i_read_strobe_n && i_write_strobe_n && i_zero_wait && i_rd_fifo_bytes >= 4'h4)[*8]
      |-> !o_async_wait_release_oe;
  endproperty
  property p_wr;
    (!i_write_strobe_n && i_read_strobe_n && i_zero_wait && i_wr_fifo_full)[*8]
      |-> o_async_wait_release_oe;
  endproperty
  property p_idle; (i_read_strobe_n && i_write_strobe_n)[*8] |-> !o_async_wait_release_oe;
  endproperty
  property p_irq; $past(i_rst_n) && $past(i_ce) |-> o_host_irq_out == $past(i_status_event);
  endproperty
  property p_hit; $past(i_rst_n) && $past(i_ce) |-> o_local_decode_hit_n == !$past(hit);
  endproperty
  property p_mode; $fell(o_sync_done_n) |-> !i_bus_mode_select_n; endproperty
  // Data path select seen after the sampler latency
  property p_dsel; (!i_datapath_select_n)[*6] |-> o_datapath_active; endproperty
  property p_dsel_off; (i_datapath_select_n)[*6] |-> !o_datapath_active; endproperty
  // EISA mode never drives the completion output
  property p_eisa;
    i_bus_mode_select_n && $past(i_bus_mode_select_n) |-> o_sync_done_n;
  endproperty
  a_pin: assert property (p_pin) else $error("wait pin driven high");
  a_nowait: assert property (p_nowait) else $error("no stall without zero wait");
  a_rd: assert property (p_rd) else $error("no stall on short read");
  a_rd_ok: assert property (p_rd_ok) else $error("stall on ready read");
  a_wr: assert property (p_wr) else $error("no stall on full write");
  a_idle: assert property (p_idle) else $error("stall while idle");
  a_irq: assert property (p_irq) else $error("interrupt not following event");
  a_hit: assert property (p_hit) else $error("decode hit wrong");
  a_mode: assert property (p_mode) else $error("sync done outside VL mode");
  a_dsel: assert property (p_dsel) else $error("data path select not seen");
  a_dsel_off: assert property (p_dsel_off) else $error("data path active when idle");
  a_eisa: assert property (p_eisa) else $error("sync done driven in EISA mode");
endmodule : hbh_port_checker

bind hbh_port hbh_port_checker u_chk (.*);

//--- test/hbh_host_model.sv
// Host bus model running synchronous write and read cycles
`timescale 1ns/1ps
module hbh_host_model (
  // Crystal clock for pacing
  input wire logic i_mclk,
  // Host side pins
  output logic o_clk, o_cyc_n, o_sel_n, o_dir, o_rdy_n,
  output logic [31:0] o_data
);
  // Idle: clock still, select off, data not held
  initial begin
    o_clk = 1'b0; o_cyc_n = 1'b1; o_sel_n = 1'b1; o_dir = 1'b0; o_rdy_n = 1'b0; o_data = '1;
  end
  // Half of a 160 ns bus period
  task automatic half();
    repeat (4) @(negedge i_mclk);
  endtask : half
  // One data path cycle, n more bus periods after the start
  task automatic cyc(input logic w, input logic [31:0] d, input int n);
    o_sel_n = 1'b0; o_cyc_n = 1'b0; o_dir = w; o_data = d; o_rdy_n = 1'b1;
    half(); o_clk = 1'b1; half(); o_clk = 1'b0; o_cyc_n = 1'b1;
    repeat (n) begin
      half(); o_clk = 1'b1; half(); o_clk = 1'b0;
    end
    o_sel_n = 1'b1; o_rdy_n = 1'b0; o_data = ~d; // Released data shows stale inverse
  endtask : cyc
endmodule : hbh_host_model

//--- test/hbh_port_tb_top.sv
// Testbench for the host bus handshake port
`timescale 1ns/1ps
module hbh_port_tb_top;
  import hbh_pkg::*;
  logic i_mclk, i_rst_n, rd_n, wr_n, mode_n, qual_n, zw, full, ev, w_rdy, rand_rdy;
  logic bclk, cyc_n, sel_n, dir, rdy_n, wo, woe, done_n, irq, hit_n, wvalid, dact, ce;
  logic [31:0] data, seed = 32'hCCA2DDCD;
  logic [15:4] addr;
  logic [7:0] base;
  logic [3:0] ben, bytes;
  hbh_word_t word;
  hbh_word_t exp_q[$];
  int n_fail = 0, n_tests = 0;
  int n_done = 0;
  logic done_q = 1'b1;
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13; seed ^= seed >> 17; seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // Count and report one comparison
  task chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  // Verdict and end of run
  task finish_test();
    $display("Checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end
  hbh_host_model host (.i_mclk(i_mclk), .o_clk(bclk), .o_cyc_n(cyc_n), .o_sel_n(sel_n),
    .o_dir(dir), .o_rdy_n(rdy_n), .o_data(data));
  hbh_port dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce), .i_local_bus_clock(bclk),
    .i_read_strobe_n(rd_n), .i_write_strobe_n(wr_n), .i_ready_return_in_n(rdy_n),
    .i_datapath_select_n(sel_n), .i_cycle_n(cyc_n), .i_direction_select(dir),
    .i_bus_mode_select_n(mode_n), .i_address_qualifier_n(qual_n), .i_addr(addr),
    .i_byte_lane_enable_n(ben), .i_host_data(data), .i_zero_wait(zw), .i_base_high(base),
    .i_rd_fifo_bytes(bytes), .i_wr_fifo_full(full), .i_status_event(ev),
    .o_async_wait_release_o(wo), .o_async_wait_release_oe(woe), .o_sync_done_n(done_n),
    .o_host_irq_out(irq), .o_local_decode_hit_n(hit_n), .o_datapath_active(dact),
    .o_word_valid(wvalid), .i_word_ready(w_rdy), .o_word(word));
  // Receiver stalls at random once enabled
  always @(negedge i_mclk) if (rand_rdy) w_rdy <= ^rnd();
  // Words leaving the buffer against the oldest note
  always @(posedge i_mclk) if (i_rst_n && wvalid && w_rdy) begin
    if (exp_q.size() == 0) chk(1'b0, "unexpected word");
    else chk(word === exp_q.pop_front(), "word mismatch");
  end
  // Count completion strobes, one per VL cycle
  always @(negedge i_mclk) begin
    if (done_q === 1'b1 && done_n === 1'b0) n_done++;
    done_q = done_n;
  end
  // Hang guard
  initial begin
    #100us;
    n_fail++;
    finish_test();
  end
  initial begin
    logic [31:0] r;
    rd_n = 1'b1; wr_n = 1'b1; mode_n = 1'b0; qual_n = 1'b1; zw = 1'b1; full = 1'b0;
    ev = 1'b0; w_rdy = 1'b0; rand_rdy = 1'b0; addr = '0; ben = '0; base = '0; bytes = '0;
    ce = 1'b1;
    i_rst_n = 1'b0;
    repeat (8) @(negedge i_mclk);
    i_rst_n = 1'b1;
    repeat (4) @(negedge i_mclk);
    // Decode and interrupt, one cycle behind the pins
    repeat (60) begin
      r = rnd();
      addr = r[11:0]; base = r[31] ? r[11:4] : r[27:20]; qual_n = r[30]; ev = r[29];
      @(negedge i_mclk);
      chk(irq === ev, "interrupt");
      chk(hit_n === !(!qual_n && addr[15:8] === base), "decode");
    end
    // Clock enable low freezes the registered outputs
    ce = 1'b0;
    r[0] = irq;
    ev = !irq;
    repeat (3) @(negedge i_mclk);
    chk(irq === r[0], "enable low did not freeze");
    ce = 1'b1;
    // Wait line over random strobe and core levels
    repeat (40) begin
      r = rnd();
      rd_n = r[1:0] != 2'h1; wr_n = r[1:0] != 2'h2; zw = r[2] | r[3];
      bytes = r[7:4]; full = r[8];
      repeat (12) @(negedge i_mclk);
      chk(woe === (!(rd_n & wr_n) && (!zw || (!rd_n && bytes < 4'h4) || (!wr_n && full))),
        "wait");
      chk(wo === 1'b0, "wait level");
    end
    rd_n = 1'b1; wr_n = 1'b1; qual_n = 1'b1;
    // Data path writes then reads in both modes; first two writes meet a stalled receiver
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      mode_n = k[0]; ben = r[3:0];
      if (k < 6) exp_q.push_back({1'b1, r});
      host.cyc(k < 6, r, 2);
      repeat (6) @(negedge i_mclk);
      chk(dact === 1'b0 && done_n === 1'b1, "select or done not idle");
      if (k == 1) begin
        chk(wvalid === 1'b1, "buffer lost stalled word");
        rand_rdy = 1'b1;
      end
    end
    for (int k = 0; k < 200 && exp_q.size() > 0; k++) @(negedge i_mclk);
    chk(exp_q.size() == 0, "words missing");
    chk(n_done == 4, "sync done count");
    finish_test();
  end
endmodule : hbh_port_tb_top
